// ===== hdl/wt_cache_consts.vh
`ifndef WT_CACHE_CONSTS_VH
`define WT_CACHE_CONSTS_VH
// cache geometry
`define CACHE_ENTRIES     16384
`define CACHE_IDX_W       14
`define CACHE_TAG_W       8
`define WORD_W            32
// processor word address: 22 bits cover 16M bytes
`define CPU_ADDR_W        22
`define SYS_ADDR_W        23
// wait states per access kind
`define WAIT_PIPE         2
`define WAIT_NONPIPE      3
// dram size: base module plus one expansion, 4M words
`define DRAM_WORDS        4194304
`endif

// ===== hdl/dram_parity_store.v
`timescale 1ns/1ps
`include "wt_cache_consts.vh"
// dual-view word store with one parity bit per byte
module dram_parity_store (
	input  wire                     i_clk,
	input  wire [`CPU_ADDR_W-1:0]   i_addr,
	input  wire                     i_we,
	input  wire [3:0]               i_be,
	input  wire [`WORD_W-1:0]       i_wdata,
	output reg  [`WORD_W-1:0]       o_rdata,
	output reg  [3:0]               o_rpar
);
	reg [35:0] mem [0:`DRAM_WORDS-1];
	integer b;

	function par;
		input [7:0] d;
		begin
			par = ~^d;
		end
	endfunction

	always @(posedge i_clk) begin
		if (i_we) begin
			for (b = 0; b < 4; b = b + 1) begin
				if (i_be[b]) begin
					mem[i_addr][b*8 +: 8] <= i_wdata[b*8 +: 8];
					mem[i_addr][32+b] <= par(i_wdata[b*8 +: 8]);
				end
			end
		end
		o_rdata <= mem[i_addr][31:0];
		o_rpar  <= mem[i_addr][35:32];
	end
endmodule

// ===== hdl/write_through_cache_dram_port.v
`timescale 1ns/1ps
`include "wt_cache_consts.vh"
module write_through_cache_dram_port (
	input  wire                     i_clk,
	input  wire                     i_reset_n,
	input  wire                     i_pipelined,
	input  wire                     i_exp_present,
	input  wire                     i_cpu_req,
	input  wire                     i_cpu_we,
	input  wire [`CPU_ADDR_W-1:0]   i_cpu_addr,
	input  wire [3:0]               i_cpu_be,
	input  wire [`WORD_W-1:0]       i_cpu_wdata,
	output reg                      o_cpu_ready,
	output reg  [`WORD_W-1:0]       o_cpu_rdata,
	output reg                      o_cpu_hit,
	output reg                      o_cpu_miss_range,
	input  wire                     i_sys_req,
	input  wire                     i_sys_we,
	input  wire [`SYS_ADDR_W-1:0]   i_sys_addr,
	input  wire [1:0]               i_sys_be,
	input  wire [15:0]              i_sys_wdata,
	output reg                      o_sys_ready,
	output reg  [15:0]              o_sys_rdata,
	input  wire                     i_parity_clear,
	output reg                      o_parity_irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_CPU  = 3'h1;
	localparam ST_SYS  = 3'h2;
	localparam ST_FIN  = 3'h3;

	reg  [`WORD_W-1:0]      c_data  [0:`CACHE_ENTRIES-1];
	reg  [`CACHE_TAG_W-1:0] c_tag   [0:`CACHE_ENTRIES-1];
	reg  [`CACHE_ENTRIES-1:0] c_valid;

	reg  [2:0]              state;
	reg  [1:0]              wcnt;
	reg                     op_we;
	reg                     op_sys;
	reg                     op_hi;
	reg  [`CPU_ADDR_W-1:0]  op_addr;
	reg  [3:0]              op_be;
	reg  [`WORD_W-1:0]      op_wdata;
	reg                     sys_req_q;
	reg                     sys_req_s;
	reg                     sys_we_q;
	reg                     sys_we_s;
	reg  [`SYS_ADDR_W-1:0]  sys_addr_q;
	reg  [`SYS_ADDR_W-1:0]  sys_addr_s;
	reg  [1:0]              sys_be_q;
	reg  [1:0]              sys_be_s;
	reg  [15:0]             sys_wd_q;
	reg  [15:0]             sys_wd_s;
	reg                     sys_hold;

	wire [`WORD_W-1:0]      d_rdata;
	wire [3:0]              d_rpar;
	reg                     d_we;

	function [`CACHE_IDX_W-1:0] idx_of;
		input [`CPU_ADDR_W-1:0] a;
		begin
			idx_of = a[`CACHE_IDX_W-1:0];
		end
	endfunction

	function [`CACHE_TAG_W-1:0] tag_of;
		input [`CPU_ADDR_W-1:0] a;
		begin
			tag_of = a[`CPU_ADDR_W-1:`CACHE_IDX_W];
		end
	endfunction

	// base module low 8M, expansion high 8M
	function in_range;
		input [`CPU_ADDR_W-1:0] a;
		input                   exp;
		begin
			in_range = ~a[`CPU_ADDR_W-1] | exp;
		end
	endfunction

	function par_bad;
		input [`WORD_W-1:0] d;
		input [3:0]         p;
		input [3:0]         be;
		integer k;
		begin
			par_bad = 1'b0;
			for (k = 0; k < 4; k = k + 1)
				if (be[k] && (p[k] != ~^d[k*8 +: 8]))
					par_bad = 1'b1;
		end
	endfunction

	wire [`CACHE_IDX_W-1:0] ci = idx_of(i_cpu_addr);
	wire cpu_hit = c_valid[ci] && (c_tag[ci] == tag_of(i_cpu_addr));
	wire [1:0] waits = i_pipelined ? 2'h2 : 2'h3;

	// 16-bit system port mapped onto 32-bit words
	wire [`CPU_ADDR_W-1:0] sys_word = sys_addr_s[`SYS_ADDR_W-1:1];
	wire [3:0] sys_be4 = sys_addr_s[0] ? {sys_be_s, 2'h0}
		: {2'h0, sys_be_s};
	wire [`WORD_W-1:0] sys_wd32 = {sys_wd_s, sys_wd_s};

	dram_parity_store u_dram (
		.i_clk   (i_clk),
		.i_addr  (op_addr),
		.i_we    (d_we),
		.i_be    (op_be),
		.i_wdata (op_wdata),
		.o_rdata (d_rdata),
		.o_rpar  (d_rpar)
	);

	wire [`CACHE_IDX_W-1:0] oi = idx_of(op_addr);

	always @(posedge i_clk) begin
		if (state == ST_FIN && op_we) begin
			// write-through update of a present entry
			if (c_valid[oi] && c_tag[oi] == tag_of(op_addr)) begin
				if (op_be[0]) c_data[oi][7:0]   <= op_wdata[7:0];
				if (op_be[1]) c_data[oi][15:8]  <= op_wdata[15:8];
				if (op_be[2]) c_data[oi][23:16] <= op_wdata[23:16];
				if (op_be[3]) c_data[oi][31:24] <= op_wdata[31:24];
			end
		end else if (state == ST_FIN && !op_sys
				&& !par_bad(d_rdata, d_rpar, 4'hF)) begin
			c_data[oi] <= d_rdata;
			c_tag[oi]  <= tag_of(op_addr);
		end
	end

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state            <= ST_IDLE;
			wcnt             <= 2'h0;
			op_we            <= 1'b0;
			op_sys           <= 1'b0;
			op_hi            <= 1'b0;
			op_addr          <= {`CPU_ADDR_W{1'b0}};
			op_be            <= 4'h0;
			op_wdata         <= 32'h00000000;
			d_we             <= 1'b0;
			c_valid          <= {`CACHE_ENTRIES{1'b0}};
			o_cpu_ready      <= 1'b0;
			o_cpu_rdata      <= 32'h00000000;
			o_cpu_hit        <= 1'b0;
			o_cpu_miss_range <= 1'b0;
			o_sys_ready      <= 1'b0;
			o_sys_rdata      <= 16'h0000;
			o_parity_irq     <= 1'b0;
			sys_req_q        <= 1'b0;
			sys_req_s        <= 1'b0;
			sys_we_q         <= 1'b0;
			sys_we_s         <= 1'b0;
			sys_addr_q       <= {`SYS_ADDR_W{1'b0}};
			sys_addr_s       <= {`SYS_ADDR_W{1'b0}};
			sys_be_q         <= 2'h0;
			sys_be_s         <= 2'h0;
			sys_wd_q         <= 16'h0000;
			sys_wd_s         <= 16'h0000;
			sys_hold         <= 1'b0;
		end else begin
			// system port inputs pass two flops
			sys_req_q   <= i_sys_req;
			sys_req_s   <= sys_req_q;
			sys_we_q    <= i_sys_we;
			sys_we_s    <= sys_we_q;
			sys_addr_q  <= i_sys_addr;
			sys_addr_s  <= sys_addr_q;
			sys_be_q    <= i_sys_be;
			sys_be_s    <= sys_be_q;
			sys_wd_q    <= i_sys_wdata;
			sys_wd_s    <= sys_wd_q;
			// one transfer per request, wait for its drop
			if (!sys_req_s)
				sys_hold <= 1'b0;
			o_cpu_ready <= 1'b0;
			o_cpu_hit   <= 1'b0;
			o_cpu_miss_range <= 1'b0;
			o_sys_ready <= 1'b0;
			d_we        <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (i_cpu_req && !in_range(i_cpu_addr, i_exp_present)) begin
					o_cpu_ready      <= 1'b1;
					o_cpu_miss_range <= 1'b1;
				end else if (i_cpu_req && !i_cpu_we && cpu_hit) begin
					o_cpu_ready <= 1'b1;
					o_cpu_hit   <= 1'b1;
					o_cpu_rdata <= c_data[ci];
				end else if (i_cpu_req) begin
					state    <= ST_CPU;
					wcnt     <= waits - 2'h1;
					op_we    <= i_cpu_we;
					op_sys   <= 1'b0;
					op_addr  <= i_cpu_addr;
					op_be    <= i_cpu_we ? i_cpu_be : 4'hF;
					op_wdata <= i_cpu_wdata;
					d_we     <= i_cpu_we;
				end else if (sys_req_s && !sys_hold) begin
					sys_hold <= 1'b1;
					state    <= ST_SYS;
					wcnt     <= 2'h1;
					op_we    <= sys_we_s;
					op_sys   <= 1'b1;
					op_hi    <= sys_addr_s[0];
					op_addr  <= sys_word;
					op_be    <= sys_be4;
					op_wdata <= sys_wd32;
					d_we     <= sys_we_s;
				end
			end
			ST_CPU, ST_SYS: begin
				if (wcnt == 2'h1)
					state <= ST_FIN;
				else
					wcnt <= wcnt - 2'h1;
			end
			ST_FIN: begin
				state <= ST_IDLE;
				if (!op_we && par_bad(d_rdata, d_rpar, op_be))
					o_parity_irq <= 1'b1;
				if (!op_we && !op_sys)
					c_valid[oi] <= ~par_bad(d_rdata, d_rpar, 4'hF);
				else if (op_we && !op_sys)
					c_valid[oi] <= c_valid[oi];
				if (op_sys) begin
					o_sys_ready <= 1'b1;
					o_sys_rdata <= op_hi ? d_rdata[31:16] : d_rdata[15:0];
				end else begin
					o_cpu_ready <= 1'b1;
					o_cpu_rdata <= d_rdata;
				end
			end
			default: state <= ST_IDLE;
			endcase
			if (i_parity_clear && !(state == ST_FIN && !op_we
					&& par_bad(d_rdata, d_rpar, op_be)))
				o_parity_irq <= 1'b0;
		end
	end
endmodule

// ===== sim/wt_cache_props.sv
`timescale 1ns/1ps
`include "wt_cache_consts.vh"
module wt_cache_props (
	input wire                   i_clk,
	input wire                   i_reset_n,
	input wire                   i_pipelined,
	input wire                   i_exp_present,
	input wire                   i_cpu_req,
	input wire                   i_cpu_we,
	input wire [`CPU_ADDR_W-1:0] i_cpu_addr,
	input wire                   o_cpu_ready,
	input wire                   o_cpu_hit,
	input wire                   o_cpu_miss_range,
	input wire                   o_sys_ready,
	input wire                   i_parity_clear,
	input wire                   o_parity_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire inr = !i_cpu_addr[21] || i_exp_present;
	ready_one_cycle_a: assert property (
		o_cpu_ready |=> !o_cpu_ready) else $error("ready too long");
	hit_zero_wait_a: assert property (
		o_cpu_hit |-> o_cpu_ready && $past(i_cpu_req)
		&& !$past(i_cpu_req, 2)) else $error("hit not zero wait");
	hit_only_read_a: assert property (
		o_cpu_hit |-> !$past(i_cpu_we)) else $error("hit on a write");
	write_pipe_a: assert property (
		$rose(i_cpu_req) && i_cpu_we && i_pipelined && inr
		|-> !o_cpu_ready [*3] ##1 o_cpu_ready) else $error("pipe write");
	write_slow_a: assert property (
		$rose(i_cpu_req) && i_cpu_we && !i_pipelined && inr
		|-> !o_cpu_ready [*4] ##1 o_cpu_ready) else $error("slow write");
	range_flag_a: assert property (
		o_cpu_ready |-> o_cpu_miss_range ==
		($past(i_cpu_addr[21]) && !$past(i_exp_present)))
		else $error("range flag wrong");
	range_fast_a: assert property (
		$rose(i_cpu_req) && !inr |-> ##1 o_cpu_miss_range)
		else $error("range answer late");
	sys_pulse_a: assert property (
		o_sys_ready |=> !o_sys_ready) else $error("sys ready too long");
	parity_on_read_a: assert property (
		$rose(o_parity_irq) |-> o_cpu_ready || o_sys_ready)
		else $error("parity irq without a read");
	parity_clear_a: assert property (
		$fell(o_parity_irq) |-> $past(i_parity_clear))
		else $error("parity irq dropped without clear");
	cover property (o_cpu_hit);
	cover property ($rose(o_parity_irq));
	cover property (o_cpu_miss_range);
	cover property (o_sys_ready);
endmodule
bind write_through_cache_dram_port wt_cache_props u_props (.i_clk,
	.i_reset_n, .i_pipelined, .i_exp_present, .i_cpu_req, .i_cpu_we,
	.i_cpu_addr, .o_cpu_ready, .o_cpu_hit, .o_cpu_miss_range,
	.o_sys_ready, .i_parity_clear, .o_parity_irq);

// ===== sim/sys_port_master.sv
`timescale 1ns/1ps
module sys_port_master (
	input  wire        i_clk,
	input  wire        i_sys_ready,
	input  wire [15:0] i_sys_rdata,
	output reg         o_sys_req = 0,
	output reg         o_sys_we = 0,
	output reg  [22:0] o_sys_addr = 0,
	output reg  [1:0]  o_sys_be = 0,
	output reg  [15:0] o_sys_wdata = 0
);
	int n;
	task automatic xfer(input logic w, input logic [22:0] a,
		input logic [15:0] d, output logic [15:0] rd);
		@(negedge i_clk);
		o_sys_req = 1;
		o_sys_we = w;
		o_sys_addr = a;
		o_sys_be = 2'h3;
		o_sys_wdata = d;
		n = 0;
		do begin @(negedge i_clk); n++; end while (!i_sys_ready && n < 40);
		rd = i_sys_rdata;
		o_sys_req = 0;
		o_sys_addr = ~a;
		o_sys_wdata = ~d;
	endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "wt_cache_consts.vh"
module testbench;
	logic i_clk = 0, i_reset_n = 0, i_pipelined = 1, i_exp_present = 1;
	logic i_cpu_req = 0, i_cpu_we = 0, i_parity_clear = 0, hit, rng;
	logic [21:0] i_cpu_addr = 0, a, pool [8];
	logic [3:0] i_cpu_be = 0;
	logic [31:0] i_cpu_wdata = 0, o_cpu_rdata, rd, d;
	logic o_cpu_ready, o_cpu_hit, o_cpu_miss_range, o_sys_ready;
	logic i_sys_req, i_sys_we, o_parity_irq;
	logic [22:0] i_sys_addr;
	logic [1:0] i_sys_be;
	logic [15:0] i_sys_wdata, o_sys_rdata, sd;
	logic [31:0] mem [int];
	logic [8:0] ct [0:16383];
	int bad_count = 0, comparisons = 0, lat;
	write_through_cache_dram_port DUT (.i_clk, .i_reset_n, .i_pipelined,
		.i_exp_present, .i_cpu_req, .i_cpu_we, .i_cpu_addr, .i_cpu_be,
		.i_cpu_wdata, .o_cpu_ready, .o_cpu_rdata, .o_cpu_hit,
		.o_cpu_miss_range, .i_sys_req, .i_sys_we, .i_sys_addr, .i_sys_be,
		.i_sys_wdata, .o_sys_ready, .o_sys_rdata, .i_parity_clear,
		.o_parity_irq);
	sys_port_master P (.i_clk, .i_sys_ready(o_sys_ready),
		.i_sys_rdata(o_sys_rdata), .o_sys_req(i_sys_req),
		.o_sys_we(i_sys_we), .o_sys_addr(i_sys_addr),
		.o_sys_be(i_sys_be), .o_sys_wdata(i_sys_wdata));
	always #2 i_clk = ~i_clk;
	task check(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task results;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task cpu(input logic w, input logic [21:0] ad, input logic [3:0] b,
		input logic [31:0] wd);
		@(negedge i_clk);
		i_cpu_req = 1;
		i_cpu_we = w;
		i_cpu_addr = ad;
		i_cpu_be = b;
		i_cpu_wdata = wd;
		lat = 0;
		do begin @(negedge i_clk); lat++; end while (!o_cpu_ready && lat < 20);
		rd = o_cpu_rdata;
		hit = o_cpu_hit;
		rng = o_cpu_miss_range;
		i_cpu_req = 0;
		i_cpu_wdata = ~wd;
	endtask
	function logic [31:0] merge(logic [31:0] o, n, logic [3:0] b);
		for (int k = 0; k < 4; k++) if (b[k]) o[8*k+:8] = n[8*k+:8];
		return o;
	endfunction
	task op(input logic w, input logic [21:0] ad, input logic [3:0] b);
		logic h;
		int el;
		h = ct[ad[13:0]] === {1'b1, ad[21:14]};
		d = $urandom;
		i_pipelined = 1'($urandom);
		cpu(w, ad, b, d);
		if (w) mem[ad] = merge(mem[ad], d, b);
		else begin
			check(rd, mem[ad]);
			check(hit, h);
			ct[ad[13:0]] = {1'b1, ad[21:14]};
		end
		el = i_pipelined ? `WAIT_PIPE : `WAIT_NONPIPE;
		check(lat, (!w && h) ? 1 : el + 1);
	endtask
	initial begin
		for (int k = 0; k < 16384; k++) ct[k] = 0;
		void'($urandom(63660));
		repeat (6) @(negedge i_clk);
		check({o_cpu_ready, o_sys_ready, o_parity_irq}, 0);
		i_reset_n = 1;
		for (int k = 0; k < 8; k++) begin
			pool[k] = {1'b0, 7'($urandom), k[0] ? 14'h3FFF : 14'h0000};
			op(1, pool[k], 4'hF);
		end
		repeat (300) op(1'($urandom), pool[$urandom % 8], 4'($urandom) | 4'h1);
		$display("test random done");
		a = pool[2];
		op(0, a, 4'hF);
		sd = $urandom;
		mem[a][31:16] = sd;
		P.xfer(1, {a, 1'b1}, sd, sd);
		check(P.n < 40, 1);
		op(0, a, 4'hF);
		P.xfer(0, {a, 1'b0}, 16'h0000, sd);
		check(sd, mem[a][15:0]);
		$display("test system port done");
		i_exp_present = 0;
		a = {1'b1, 21'($urandom)};
		cpu(1, a, 4'hF, 32'h0000_0000);
		check({rng, lat[3:0]}, 5'h11);
		cpu(0, a, 4'hF, 32'h0000_0000);
		check(rng, 1);
		i_exp_present = 1;
		op(1, a, 4'hF);
		op(0, a, 4'hF);
		$display("test range done");
		a = {1'b0, 7'($urandom), 14'h1555};
		op(1, a, 4'hF);
		DUT.u_dram.mem[a][32] = ~DUT.u_dram.mem[a][32];
		repeat (2) begin
			op(0, a, 4'hF);
			ct[a[13:0]] = 0;
			check(o_parity_irq, 1);
		end
		i_parity_clear = 1;
		@(negedge i_clk);
		i_parity_clear = 0;
		check(o_parity_irq, 0);
		$display("test parity done");
		results;
	end
	initial begin
		#100000;
		bad_count++;
		results;
	end
endmodule
